// file: design/bpt_cfg.svh
// What this block does
// R1: sample data, signaling; update pulse on active edge
// R2: software selects rising or falling active edge
// R3: master modes drive transmit clock pin out
// R4: T1 Nx64 gaps framing bit, optional channels
// R5: E1 Nx64 gaps selected channel timeslots
// R6: clear channel: unframed data, no alignment, signaling
// R7: slave modes: clock pin is input, 1.544/2.048MHz
// R8: H-MVIP slave: clock pin input and ignored
// R9: after reset clock pin is an input
// R10: backplane puts signaling in bits 5-8
// R11: H-MVIP slave: signaling input ignored
// R12: T1 frame pulse every multiple of 193 bits
// R13: T1 superframe pulse marks frame 1 when enabled
// R14: E1 frame pulse every multiple of 256 bits
// R15: E1 multiframe pulse high signaling, low after CRC
// R16: frame pulse output: one-cycle pulse at frame start
// R17: after reset frame pulse pin is an input
// R18: four independent per-channel instances
`ifndef BPT_CFG_SVH
`define BPT_CFG_SVH
`define BPT_T1_FRAME_BITS 9'd193
`define BPT_E1_FRAME_BITS 9'd256
`define BPT_T1_SF_FRAMES 5'd12
`define BPT_T1_ESF_FRAMES 5'd24
`define BPT_E1_MF_FRAMES 5'd16
`define BPT_SIG_FIRST_IDX 3'd4
`define BPT_SYS_CLK_KHZ 10000
`define BPT_T1_CLK_KHZ 1544
`define BPT_E1_CLK_KHZ 2048
`define BPT_HALF_T1 4'(`BPT_SYS_CLK_KHZ / (2 * `BPT_T1_CLK_KHZ))
`define BPT_HALF_E1 4'(`BPT_SYS_CLK_KHZ / (2 * `BPT_E1_CLK_KHZ))
`define BPT_T1_LAST_BIT 8'(`BPT_T1_FRAME_BITS - 9'd1)
`define BPT_E1_LAST_BIT 8'(`BPT_E1_FRAME_BITS - 9'd1)
`define BPT_LINK_RST_CYCLES 6'd60
`endif

// file: design/bpt_pkg.sv
package bpt_pkg;
  typedef enum logic [4:0]
  {
    BPT_SLAVE = 5'h01,
    BPT_MASTER = 5'h02,
    BPT_NX64 = 5'h04,
    BPT_CLEAR = 5'h08,
    BPT_HMVIP = 5'h10
  } bpt_mode_t;

  typedef struct packed
  {
    bpt_mode_t mode;
    logic e1;
    logic sf_en;
    logic esf;
    logic fp_out;
    logic fp_multi;
  } bpt_dcfg_t;

  typedef struct packed
  {
    logic e1;
    logic esf;
    logic multi;
    logic [7:0] byte_v;
    logic [3:0] nib;
  } bpt_hcfg_t;
endpackage

// file: design/bpt_link_if.sv
`timescale 1ns/1ns
interface bpt_link_if;
  logic clk_dev_o;
  logic clk_dev_oe;
  logic clk_host_o;
  logic clk_host_oe;
  logic fp_dev_o;
  logic fp_dev_oe;
  logic fp_host_o;
  logic fp_host_oe;
  logic bp_tx_data_in;
  logic bp_tx_signaling_in;
  logic bp_tx_clock;
  logic bp_tx_frame_pulse;

  // undriven pins read low, as with the recommended pull-down
  assign bp_tx_clock = clk_dev_oe ? clk_dev_o : (clk_host_oe & clk_host_o);
  assign bp_tx_frame_pulse = fp_dev_oe ? fp_dev_o : (fp_host_oe & fp_host_o);

  modport dev
  (
    input bp_tx_clock,
    input bp_tx_frame_pulse,
    input bp_tx_data_in,
    input bp_tx_signaling_in,
    output clk_dev_o,
    output clk_dev_oe,
    output fp_dev_o,
    output fp_dev_oe
  );

  modport host
  (
    input bp_tx_clock,
    input bp_tx_frame_pulse,
    output clk_host_o,
    output clk_host_oe,
    output fp_host_o,
    output fp_host_oe,
    output bp_tx_data_in,
    output bp_tx_signaling_in
  );
endinterface

// file: design/bpt_dev_end.sv
`timescale 1ns/1ns
`include "bpt_cfg.svh"
// one channel; each instance shares nothing with any other (see R18)
module bpt_dev_end
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  bpt_link_if.dev LINK,
  input wire bpt_pkg::bpt_mode_t MODE_I,
  input wire logic E1_I,
  input wire logic FALLING_EDGE_I,
  input wire logic SF_ALIGN_EN_I,
  input wire logic ESF_I,
  input wire logic FP_OUTPUT_I,
  input wire logic FP_MULTI_I,
  input wire logic [31:0] GAP_MASK_I,
  output logic TX_BIT_O,
  output logic TX_SIG_O,
  output logic TX_FRAME_START_O,
  output logic TX_MF_START_O,
  output logic TX_STROBE_O
);
  typedef struct packed
  {
    logic [3:0] div;
    logic phase;
    logic [7:0] pos;
    logic clk_o;
    logic clk_oe;
    logic fp_oe;
    logic [2:0] tsync;
    logic seen;
    logic bit_v;
    logic sig;
    logic sof;
    logic smf;
    logic stb;
    logic [5:0] hold;
    logic lrst;
  } bpt_dsys_t;

  typedef struct packed
  {
    logic [2:0] rst;
    bpt_pkg::bpt_dcfg_t c1;
    bpt_pkg::bpt_dcfg_t c2;
    bpt_pkg::bpt_dcfg_t c3;
    bpt_pkg::bpt_dcfg_t cfg;
    logic fp_prev;
    logic [7:0] bcnt;
    logic [4:0] fcnt;
    logic data;
    logic sig;
    logic sof;
    logic smf;
    logic tog;
    logic fp_o;
  } bpt_dlink_t;

  bpt_dsys_t s_r;
  bpt_dsys_t s_nxt;
  bpt_dlink_t l_r;
  bpt_dlink_t l_nxt;
  bpt_pkg::bpt_dcfg_t dcfg;
  logic link_clk;
  logic master;

  // clock bit slot gapped in Nx64: T1 bit 0 is framing, channels start at bit 1
  function automatic logic slot_gapped(input logic [7:0] pos, input logic e1,
                                       input logic [31:0] mask);
    logic [7:0] p;
    p = e1 ? pos : pos - 8'h01;
    if (!e1 && pos == 8'h00)
      return 1'b1; // see R4
    return mask[p[7:3]]; // see R4 see R5
  endfunction

  assign dcfg = '{mode: MODE_I, e1: E1_I, sf_en: SF_ALIGN_EN_I, esf: ESF_I,
                  fp_out: FP_OUTPUT_I, fp_multi: FP_MULTI_I};
  // edge select flips the clock itself; change it only while the link is idle
  assign link_clk = LINK.bp_tx_clock ^ FALLING_EDGE_I; // see R2
  assign master = MODE_I inside {bpt_pkg::BPT_MASTER, bpt_pkg::BPT_NX64,
                                 bpt_pkg::BPT_CLEAR};

  always_comb
  begin
    logic [3:0] half;
    logic [7:0] last;
    logic gap;
    half = E1_I ? `BPT_HALF_E1 : `BPT_HALF_T1;
    last = E1_I ? `BPT_E1_LAST_BIT : `BPT_T1_LAST_BIT;
    gap = 1'b0;
    s_nxt = s_r;
    s_nxt.stb = 1'b0;
    s_nxt.tsync = {s_r.tsync[1:0], l_r.tog};
    s_nxt.lrst = s_r.hold != 6'h00;
    // link side still settling: follow its toggle, report no stale bits
    if (s_r.hold != 6'h00)
    begin
      s_nxt.hold = s_r.hold - 6'h01;
      s_nxt.seen = s_r.tsync[2];
    end
    else if (s_r.tsync[1] == s_r.tsync[2] && s_r.tsync[2] != s_r.seen)
    begin
      s_nxt.seen = s_r.tsync[2];
      s_nxt.bit_v = l_r.data;
      s_nxt.sig = l_r.sig;
      s_nxt.sof = l_r.sof;
      s_nxt.smf = l_r.smf;
      s_nxt.stb = 1'b1;
    end
    // slave and H-MVIP leave the clock pin an input
    s_nxt.clk_oe = master; // see R3 see R7 see R8
    // pulse output only where frames exist and the clock is not gapped
    s_nxt.fp_oe = FP_OUTPUT_I && MODE_I inside {bpt_pkg::BPT_SLAVE,
                                                bpt_pkg::BPT_MASTER}; // see R16
    if (!master)
    begin
      s_nxt.div = 4'h0;
      s_nxt.phase = 1'b0;
      s_nxt.pos = 8'h00;
      s_nxt.clk_o = 1'b0;
    end
    else if (s_r.div >= half - 4'h1)
    begin
      s_nxt.div = 4'h0;
      s_nxt.phase = ~s_r.phase;
      if (!s_r.phase)
      begin
        if (MODE_I == bpt_pkg::BPT_NX64)
          gap = slot_gapped(s_r.pos, E1_I, GAP_MASK_I); // see R4 see R5
        s_nxt.pos = (s_r.pos == last) ? 8'h00 : s_r.pos + 8'h01;
        s_nxt.clk_o = ~gap; // see R3
      end
      else
        s_nxt.clk_o = 1'b0;
    end
    else
      s_nxt.div = s_r.div + 4'h1;
    // link logic resets only on link edges, and reset itself stops the clock
    if (SYS_RST_I)
    begin
      s_nxt = '0; // see R9 see R17
      s_nxt.hold = `BPT_LINK_RST_CYCLES;
      s_nxt.lrst = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    s_r <= s_nxt;
  end

  always_comb
  begin
    logic [7:0] last_b;
    logic [4:0] last_f;
    logic ign;
    logic clear;
    logic align;
    logic [7:0] bpos;
    logic [4:0] fpos;
    logic [7:0] nb;
    logic [4:0] nf;
    last_b = l_r.cfg.e1 ? `BPT_E1_LAST_BIT : `BPT_T1_LAST_BIT;
    last_f = l_r.cfg.e1 ? `BPT_E1_MF_FRAMES - 5'd1
           : (l_r.cfg.esf ? `BPT_T1_ESF_FRAMES - 5'd1 : `BPT_T1_SF_FRAMES - 5'd1);
    ign = l_r.cfg.mode == bpt_pkg::BPT_HMVIP;
    clear = l_r.cfg.mode == bpt_pkg::BPT_CLEAR;
    l_nxt = l_r;
    l_nxt.rst = {l_r.rst[1:0], s_r.lrst};
    l_nxt.c1 = dcfg;
    l_nxt.c2 = l_r.c1;
    l_nxt.c3 = l_r.c2;
    if (l_r.c2 == l_r.c3)
      l_nxt.cfg = l_r.c3;
    // rising edge of an input pulse marks bit 0 of a frame
    align = !clear && !ign && !l_r.cfg.fp_out && LINK.bp_tx_frame_pulse
          && !l_r.fp_prev; // see R6 see R12 see R14
    bpos = l_r.bcnt;
    fpos = l_r.fcnt;
    if (align)
    begin
      bpos = 8'h00;
      if (l_r.cfg.sf_en)
        fpos = 5'd0; // see R13 see R15
    end
    nb = (bpos == last_b) ? 8'h00 : bpos + 8'h01;
    nf = fpos;
    if (bpos == last_b)
      nf = (fpos == last_f) ? 5'd0 : fpos + 5'd1;
    l_nxt.bcnt = nb;
    l_nxt.fcnt = nf;
    l_nxt.fp_prev = LINK.bp_tx_frame_pulse;
    if (!ign)
    begin
      l_nxt.data = LINK.bp_tx_data_in; // see R1
      l_nxt.sig = clear ? 1'b0 : LINK.bp_tx_signaling_in; // see R1 see R6 see R11
      l_nxt.sof = !clear && bpos == 8'h00;
      l_nxt.smf = !clear && bpos == 8'h00 && fpos == 5'd0;
      l_nxt.tog = ~l_r.tog;
    end
    l_nxt.fp_o = l_r.cfg.fp_out && !clear && !ign && nb == 8'h00
               && (!l_r.cfg.fp_multi || nf == 5'd0); // see R1 see R16
    if (l_r.rst[2] && l_r.rst[1])
    begin
      l_nxt = '0;
      l_nxt.rst = {l_r.rst[1:0], s_r.lrst};
    end
  end

  always_ff @(posedge link_clk)
  begin
    l_r <= l_nxt;
  end

  assign LINK.clk_dev_o = s_r.clk_o;
  assign LINK.clk_dev_oe = s_r.clk_oe;
  assign LINK.fp_dev_o = l_r.fp_o;
  assign LINK.fp_dev_oe = s_r.fp_oe;
  assign TX_BIT_O = s_r.bit_v;
  assign TX_SIG_O = s_r.sig;
  assign TX_FRAME_START_O = s_r.sof;
  assign TX_MF_START_O = s_r.smf;
  assign TX_STROBE_O = s_r.stb;
endmodule

// file: design/bpt_host_end.sv
`timescale 1ns/1ns
`include "bpt_cfg.svh"
module bpt_host_end
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  bpt_link_if.host LINK,
  input wire logic MAKE_CLOCK_I,
  input wire logic DRIVE_FP_I,
  input wire logic E1_I,
  input wire logic ESF_I,
  input wire logic MULTI_ALIGN_I,
  input wire logic FALLING_EDGE_I,
  input wire logic [7:0] DATA_BYTE_I,
  input wire logic [3:0] SIG_NIBBLE_I
);
  typedef struct packed
  {
    logic [3:0] div;
    logic clk_o;
    logic clk_oe;
    logic fp_oe;
    logic [5:0] hold;
    logic lrst;
  } bpt_hsys_t;

  typedef struct packed
  {
    logic [2:0] rst;
    bpt_pkg::bpt_hcfg_t c1;
    bpt_pkg::bpt_hcfg_t c2;
    bpt_pkg::bpt_hcfg_t c3;
    bpt_pkg::bpt_hcfg_t cfg;
    logic [7:0] bcnt;
    logic [4:0] fcnt;
    logic data;
    logic sig;
    logic fp;
  } bpt_hlink_t;

  bpt_hsys_t s_r;
  bpt_hsys_t s_nxt;
  bpt_hlink_t l_r;
  bpt_hlink_t l_nxt;
  logic link_clk;

  // launch on the edge opposite the device's sampling edge for setup margin
  assign link_clk = ~(LINK.bp_tx_clock ^ FALLING_EDGE_I);

  always_comb
  begin
    logic [3:0] half;
    half = E1_I ? `BPT_HALF_E1 : `BPT_HALF_T1;
    s_nxt = s_r;
    s_nxt.clk_oe = MAKE_CLOCK_I; // see R7
    s_nxt.fp_oe = DRIVE_FP_I;
    if (!MAKE_CLOCK_I)
    begin
      s_nxt.div = 4'h0;
      s_nxt.clk_o = 1'b0;
    end
    else if (s_r.div >= half - 4'h1)
    begin
      s_nxt.div = 4'h0;
      s_nxt.clk_o = ~s_r.clk_o; // see R7
    end
    else
      s_nxt.div = s_r.div + 4'h1;
    s_nxt.lrst = s_r.hold != 6'h00;
    if (s_r.hold != 6'h00)
      s_nxt.hold = s_r.hold - 6'h01;
    // link logic resets only on link edges, which run once reset is gone
    if (SYS_RST_I)
    begin
      s_nxt = '0;
      s_nxt.hold = `BPT_LINK_RST_CYCLES;
      s_nxt.lrst = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    s_r <= s_nxt;
  end

  always_comb
  begin
    logic [7:0] last_b;
    logic [4:0] last_f;
    logic [2:0] idx;
    logic fbit;
    last_b = l_r.cfg.e1 ? `BPT_E1_LAST_BIT : `BPT_T1_LAST_BIT;
    last_f = l_r.cfg.e1 ? `BPT_E1_MF_FRAMES - 5'd1
           : (l_r.cfg.esf ? `BPT_T1_ESF_FRAMES - 5'd1 : `BPT_T1_SF_FRAMES - 5'd1);
    fbit = !l_r.cfg.e1 && l_r.bcnt == 8'h00;
    idx = l_r.cfg.e1 ? l_r.bcnt[2:0] : 3'(l_r.bcnt - 8'h01);
    l_nxt = l_r;
    l_nxt.rst = {l_r.rst[1:0], s_r.lrst};
    l_nxt.c1 = '{e1: E1_I, esf: ESF_I, multi: MULTI_ALIGN_I,
                 byte_v: DATA_BYTE_I, nib: SIG_NIBBLE_I};
    l_nxt.c2 = l_r.c1;
    l_nxt.c3 = l_r.c2;
    if (l_r.c2 == l_r.c3)
      l_nxt.cfg = l_r.c3;
    // channel bits go msb first; the framing bit carries zero
    l_nxt.data = !fbit && l_r.cfg.byte_v[3'd7 - idx];
    l_nxt.sig = !fbit && idx >= `BPT_SIG_FIRST_IDX
              && l_r.cfg.nib[2'(3'd7 - idx)]; // see R10
    // coincident E1 multiframes collapse to a single-cycle pulse
    l_nxt.fp = l_r.bcnt == 8'h00
             && (!l_r.cfg.multi || l_r.fcnt == 5'd0); // see R12 see R13 see R14 see R15
    l_nxt.bcnt = (l_r.bcnt == last_b) ? 8'h00 : l_r.bcnt + 8'h01;
    if (l_r.bcnt == last_b)
      l_nxt.fcnt = (l_r.fcnt == last_f) ? 5'd0 : l_r.fcnt + 5'd1;
    if (l_r.rst[2] && l_r.rst[1])
    begin
      l_nxt = '0;
      l_nxt.rst = {l_r.rst[1:0], s_r.lrst};
    end
  end

  always_ff @(posedge link_clk)
  begin
    l_r <= l_nxt;
  end

  assign LINK.clk_host_o = s_r.clk_o;
  assign LINK.clk_host_oe = s_r.clk_oe;
  assign LINK.fp_host_o = l_r.fp;
  assign LINK.fp_host_oe = s_r.fp_oe;
  assign LINK.bp_tx_data_in = l_r.data;
  assign LINK.bp_tx_signaling_in = l_r.sig;
endmodule

// file: test/bpt_monitor.sv
`timescale 1ns/1ns
module bpt_monitor
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic clk_dev_o,
  input wire logic clk_dev_oe,
  input wire logic fp_dev_o,
  input wire logic fp_dev_oe,
  input wire logic bp_tx_clock
);
  logic [15:0] gap_r;
  logic seen_r;
  logic drv;
  assign drv = fp_dev_oe && clk_dev_oe;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  // cycles between driven pulses; first one after reset has no reference
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      gap_r <= 16'h1;
      seen_r <= 1'h0;
    end
    else if ($rose(fp_dev_o))
    begin
      gap_r <= 16'h1;
      seen_r <= drv;
    end
    else
      gap_r <= gap_r + 16'h1;
  end
  a_reset_clk_in:
    assert property (SYS_RST_I && $past(SYS_RST_I) |-> !clk_dev_oe) else $error("clk oe");
  a_reset_fp_in:
    assert property (SYS_RST_I && $past(SYS_RST_I) |-> !fp_dev_oe) else $error("fp oe");
  a_oe_held_steady:
    assert property (disable iff (SYS_RST_I) !$past(SYS_RST_I, 2)
      |-> $stable(clk_dev_oe) && $stable(fp_dev_oe)) else $error("oe moved");
  a_clk_high_phase:
    assert property (disable iff (SYS_RST_I) $rose(clk_dev_o) && clk_dev_oe
      |-> clk_dev_o[*2] ##[1:2] !clk_dev_o) else $error("clk high");
  a_clk_low_phase:
    assert property (disable iff (SYS_RST_I) $fell(clk_dev_o) && clk_dev_oe
      |-> !clk_dev_o[*2]) else $error("clk low");
  a_pulse_one_bit:
    assert property (disable iff (SYS_RST_I) $rose(fp_dev_o) && drv
      |-> fp_dev_o[*4] ##[1:3] !fp_dev_o) else $error("fp width");
  a_pulse_on_edge:
    assert property (disable iff (SYS_RST_I) $changed(fp_dev_o) && drv
      |-> $changed(bp_tx_clock)) else $error("fp edge");
  a_pulse_frame_len:
    assert property (disable iff (SYS_RST_I) $rose(fp_dev_o) && drv && seen_r
      |-> gap_r % 16'h486 == 16'h0 || gap_r % 16'h400 == 16'h0) else $error("fp gap");
endmodule

// file: test/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  bpt_pkg::bpt_mode_t mode = bpt_pkg::BPT_SLAVE;
  logic e1 = 1'h0;
  logic fe = 1'h0;
  logic sfen = 1'h0;
  logic fpo = 1'h0;
  logic mk = 1'h1;
  logic dfp = 1'h1;
  logic [31:0] gap = 32'h0;
  logic [7:0] dbyte = 8'ha5;
  logic [3:0] nib = 4'h9;
  logic bit_o;
  logic sig_o;
  logic fs_o;
  logic mfs_o;
  logic stb_o;
  int n_mismatch = 0;
  int check_count = 0;
  int cnt;
  always #50 clk = ~clk;
  bpt_link_if bpt_link_if_i();
  bpt_dev_end bpt_dev_end_i
  (
    .CLOCK_I(clk),
    .SYS_RST_I(rst),
    .LINK(bpt_link_if_i.dev),
    .MODE_I(mode),
    .E1_I(e1),
    .FALLING_EDGE_I(fe),
    .SF_ALIGN_EN_I(sfen),
    .ESF_I(1'h0),
    .FP_OUTPUT_I(fpo),
    .FP_MULTI_I(sfen),
    .GAP_MASK_I(gap),
    .TX_BIT_O(bit_o),
    .TX_SIG_O(sig_o),
    .TX_FRAME_START_O(fs_o),
    .TX_MF_START_O(mfs_o),
    .TX_STROBE_O(stb_o)
  );
  bpt_host_end bpt_host_end_i
  (
    .CLOCK_I(clk),
    .SYS_RST_I(rst),
    .LINK(bpt_link_if_i.host),
    .MAKE_CLOCK_I(mk),
    .DRIVE_FP_I(dfp),
    .E1_I(e1),
    .ESF_I(1'h0),
    .MULTI_ALIGN_I(sfen),
    .FALLING_EDGE_I(fe),
    .DATA_BYTE_I(dbyte),
    .SIG_NIBBLE_I(nib)
  );
  bpt_monitor bpt_monitor_i
  (
    .CLOCK_I(clk),
    .SYS_RST_I(rst),
    .clk_dev_o(bpt_link_if_i.clk_dev_o),
    .clk_dev_oe(bpt_link_if_i.clk_dev_oe),
    .fp_dev_o(bpt_link_if_i.fp_dev_o),
    .fp_dev_oe(bpt_link_if_i.fp_dev_oe),
    .bp_tx_clock(bpt_link_if_i.bp_tx_clock)
  );
  task automatic check(input string nm, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic stop_if(input logic c);
    if (c)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // config only moves under reset: edge select glitches the link clock otherwise
  task automatic start(input bpt_pkg::bpt_mode_t m, input logic e, f, s, o,
    input logic [31:0] g);
    @(posedge clk);
    rst <= 1'h1;
    mode <= m;
    e1 <= e;
    fe <= f;
    sfen <= s;
    fpo <= o;
    gap <= g;
    mk <= m == bpt_pkg::BPT_SLAVE || m == bpt_pkg::BPT_HMVIP;
    dfp <= !o;
    repeat (11) @(posedge clk);
    @(negedge clk);
    check("clk_oe_rst", bpt_link_if_i.clk_dev_oe, 1'h0);
    check("fp_oe_rst", bpt_link_if_i.fp_dev_oe, 1'h0);
    @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("clk_oe", bpt_link_if_i.clk_dev_oe, !mk);
    check("fp_oe", bpt_link_if_i.fp_dev_oe, o);
    // link reset hold, then the first pulse: early frame flags are not real
    repeat (300) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic nxt;
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (stb_o !== 1'h1 && k < 100);
    stop_if(k >= 100);
  endtask
  task automatic seek(input logic m);
    cnt = 0;
    do
    begin
      nxt();
      cnt++;
    end while ((m ? mfs_o : fs_o) !== 1'h1 && cnt < 7000);
    stop_if(cnt >= 7000);
  endtask
  task automatic frame(input int nb, input logic dat);
    int p;
    seek(1'h0);
    for (int i = 1; i <= nb; i++)
    begin
      nxt();
      p = (i - 1 + e1) % 8;
      check("frame_start", fs_o, i == nb);
      if (dat && i < nb)
      begin
        check("data", bit_o, dbyte[7 - p]);
        if (p > 3)
          check("sig", sig_o, nib[7 - p]);
      end
    end
  endtask
  task automatic edges(input int cyc, input int lo);
    logic q;
    q = bpt_link_if_i.bp_tx_clock;
    cnt = 0;
    repeat (cyc)
    begin
      @(negedge clk);
      cnt += int'(bpt_link_if_i.bp_tx_clock && !q);
      q = bpt_link_if_i.bp_tx_clock;
    end
    check("gap_edges", cnt >= lo && cnt <= lo + 2, 1'h1);
  endtask
  initial
  begin
    start(bpt_pkg::BPT_SLAVE, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
    frame(193, 1'h1);
    $display("t1 slave done");
    start(bpt_pkg::BPT_SLAVE, 1'h1, 1'h1, 1'h0, 1'h0, 32'h0);
    frame(256, 1'h1);
    $display("e1 falling edge done");
    start(bpt_pkg::BPT_SLAVE, 1'h0, 1'h0, 1'h1, 1'h0, 32'h0);
    seek(1'h1);
    seek(1'h1);
    check("sf_len", cnt == 2316, 1'h1);
    $display("superframe done");
    start(bpt_pkg::BPT_MASTER, 1'h0, 1'h0, 1'h0, 1'h1, 32'h0);
    frame(193, 1'h0);
    $display("master done");
    start(bpt_pkg::BPT_NX64, 1'h0, 1'h0, 1'h0, 1'h0, 32'h1);
    edges(11580, 1839);
    start(bpt_pkg::BPT_NX64, 1'h1, 1'h0, 1'h0, 1'h0, 32'h3);
    edges(10240, 2399);
    $display("gapped clock done");
    start(bpt_pkg::BPT_CLEAR, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
    repeat (100)
    begin
      nxt();
      check("clear_sig", sig_o | fs_o | mfs_o, 1'h0);
    end
    $display("clear channel done");
    start(bpt_pkg::BPT_HMVIP, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
    cnt = 0;
    repeat (300)
    begin
      @(negedge clk);
      cnt += int'(stb_o !== 1'h0);
    end
    check("hmvip_idle", cnt == 0, 1'h1);
    $display("hmvip done");
    wrap_up();
  end
endmodule
